// file: hdl/tec_pkg.sv
// package: constants of the timer/event counter block
package tec_pkg;
  // ==========================================================
  // register indexes and byte addresses (address = 4 * index)
  localparam logic [7:0] TEC_IDX_PRELOAD = 8'h0d;
  localparam logic [7:0] TEC_IDX_CTRL    = 8'h0e;
  localparam logic [7:0] TEC_IDX_INTERRUPT_CONTROL_REG    = 8'h0f;
  localparam logic [7:0] TEC_IDX_PORTB   = 8'h10;
  localparam int         TEC_AW          = 8;
  localparam logic [TEC_AW-1:0] TEC_ADDR_PRELOAD = 8'h34;
  localparam logic [TEC_AW-1:0] TEC_ADDR_CTRL    = 8'h38;
  localparam logic [TEC_AW-1:0] TEC_ADDR_INTERRUPT_CONTROL_REG    = 8'h3c;
  localparam logic [TEC_AW-1:0] TEC_ADDR_PORTB   = 8'h40;

  // ==========================================================
  // counter_control fields
  localparam int TEC_CTL_PSC_LSB  = 0;
  localparam int TEC_CTL_PSC_MSB  = 2;
  localparam int TEC_CTL_EDGE     = 3;
  localparam int TEC_CTL_EN       = 4;
  localparam int TEC_CTL_UNUSED   = 5;
  localparam int TEC_CTL_MODE_LSB = 6;
  localparam int TEC_CTL_MODE_MSB = 7;
  localparam logic [7:0] TEC_CTL_RESET = 8'h08;

  // ==========================================================
  // interrupt_control_reg fields
  localparam int TEC_INTERRUPT_CONTROL_REG_IE   = 2;
  localparam int TEC_INTERRUPT_CONTROL_REG_FLAG = 5;
  localparam logic [7:0] TEC_INTERRUPT_CONTROL_REG_RESET = 8'h00;

  // ==========================================================
  // port b shadow: bit0/1 data latches, bit2/3 direction (1 = input), bit4 buzzer
  localparam int TEC_PB_D0  = 0;
  localparam int TEC_PB_D1  = 1;
  localparam int TEC_PB_IN0 = 2;
  localparam int TEC_PB_IN1 = 3;
  localparam int TEC_PB_BZ  = 4;
  localparam logic [7:0] TEC_PB_RESET = 8'h0f;

  localparam logic [7:0] TEC_CNT_RESET = 8'h00;
  localparam logic [7:0] TEC_CNT_MAX   = 8'hff;

  // ==========================================================
  // modes and axi answers
  typedef enum logic [1:0] {
    TEC_MODE_NONE  = 2'b00,
    TEC_MODE_EVENT = 2'b01,
    TEC_MODE_TIMER = 2'b10,
    TEC_MODE_PULSE = 2'b11
  } tec_mode_t;

  localparam logic [1:0] TEC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] TEC_RESP_SLVERR = 2'b10;
endpackage

// file: hdl/tec_tick_if.sv
// interface: prescaler select and count tick between counter and prescaler
interface tec_tick_if;
  logic [2:0] prescale_select;
  logic       tick;
  modport ctl (output prescale_select, input tick);
  modport psc (input prescale_select, output tick);
endinterface

// file: hdl/tec_prescaler.sv
// module: free-running 8-stage prescaler giving one tick per divided period
module tec_prescaler
  import tec_pkg::*;
#(
  parameter int STAGES = 8
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // select in, tick out
  tec_tick_if.psc   tk
);
  // ==========================================================
  // divider chain
  logic [STAGES-1:0] div_q;
  logic [STAGES-1:0] mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // code n divides by 2^(n+1)
  always_comb begin
    mask = STAGES'((2 << tk.prescale_select) - 1);
  end

  assign tk.tick = &(div_q | ~mask);
endmodule // tec_prescaler

// file: hdl/tec_top.sv
// module: 8-bit timer/event counter with preload, prescaler and buzzer pair
//
// Register access over AXI4-Lite was chosen for this implementation.
module tec_top
  import tec_pkg::*;
#(
  parameter int CW = 8
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // counter input pin
  input  wire logic        counter_input_pin,
  // shared port b pins
  output logic             port_b_bit0_o,
  output logic             port_b_bit0_oe,
  output logic             port_b_bit1_o,
  output logic             port_b_bit1_oe,
  // system signals
  output logic             overflow_irq,
  output logic             overflow_wake,
  output logic             freq_divider_output
);
  // ==========================================================
  // state
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] preload_q;
  logic [7:0]    ctl_q;
  logic [7:0]    interrupt_control_reg_q;
  logic [7:0]    pb_q;
  logic          pin_q;
  logic          pfd_q;
  logic          wake_q;

  typedef enum logic [1:0] {
    TEC_PW_IDLE = 2'b01,
    TEC_PW_MEAS = 2'b10
  } tec_pw_t;
  tec_pw_t pw_q;

  // ==========================================================
  // axi state
  logic          aw_held_q;
  logic [TEC_AW-1:0] aw_addr_q;
  logic          w_held_q;
  logic [31:0]   w_data_q;
  logic [3:0]    w_strb_q;
  logic          bvalid_q;
  logic [1:0]    bresp_q;
  logic          rvalid_q;
  logic [1:0]    rresp_q;
  logic [31:0]   rdata_q;

  // ==========================================================
  // prescaler
  tec_tick_if tk ();

  assign tk.prescale_select = ctl_q[TEC_CTL_PSC_MSB:TEC_CTL_PSC_LSB];

  tec_prescaler #(
    .STAGES (8)
  ) u_psc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tk      (tk)
  );

  // ==========================================================
  // decode of control fields
  tec_mode_t mode;
  logic      enable;
  logic      edge_sel;

  assign mode     = tec_mode_t'(ctl_q[TEC_CTL_MODE_MSB:TEC_CTL_MODE_LSB]);
  assign enable   = ctl_q[TEC_CTL_EN];
  assign edge_sel = ctl_q[TEC_CTL_EDGE];

  // ==========================================================
  // write channel
  logic do_write;
  logic wr_ok;
  logic wr_cnt;
  logic wr_ctl;
  logic wr_interrupt_control_reg;
  logic wr_pb;

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // both halves may arrive in either order; write once both are held
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign wr_ok    = do_write && w_strb_q[0];
  assign wr_cnt   = wr_ok && (aw_addr_q == TEC_ADDR_PRELOAD);
  assign wr_ctl   = wr_ok && (aw_addr_q == TEC_ADDR_CTRL);
  assign wr_interrupt_control_reg  = wr_ok && (aw_addr_q == TEC_ADDR_INTERRUPT_CONTROL_REG);
  assign wr_pb    = wr_ok && (aw_addr_q == TEC_ADDR_PORTB);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && !aw_held_q) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr[TEC_AW-1:0];
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && !w_held_q) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  logic addr_known_w;
  assign addr_known_w = (aw_addr_q == TEC_ADDR_PRELOAD) || (aw_addr_q == TEC_ADDR_CTRL)
                     || (aw_addr_q == TEC_ADDR_INTERRUPT_CONTROL_REG) || (aw_addr_q == TEC_ADDR_PORTB);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= TEC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= addr_known_w ? TEC_RESP_OKAY : TEC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // read channel
  logic rd_take;
  logic rd_cnt;
  logic [TEC_AW-1:0] ar_addr;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign ar_addr       = s_axi_araddr[TEC_AW-1:0];
  assign rd_take       = s_axi_arvalid && !rvalid_q;
  assign rd_cnt        = rd_take && (ar_addr == TEC_ADDR_PRELOAD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= TEC_RESP_OKAY;
      rdata_q  <= '0;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= TEC_RESP_OKAY;
      unique case (ar_addr)
        TEC_ADDR_PRELOAD: rdata_q <= {24'h000000, cnt_q};
        TEC_ADDR_CTRL:    rdata_q <= {24'h000000, ctl_q & ~(8'h01 << TEC_CTL_UNUSED)};
        TEC_ADDR_INTERRUPT_CONTROL_REG:    rdata_q <= {24'h000000, interrupt_control_reg_q};
        TEC_ADDR_PORTB:   rdata_q <= {24'h000000, pb_q};
        default: begin
          rdata_q <= '0;
          rresp_q <= TEC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // input edges
  logic pin_rise;
  logic pin_fall;
  logic act_edge;
  logic back_edge;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= counter_input_pin;
    end
  end

  assign pin_rise  = counter_input_pin && !pin_q;
  assign pin_fall  = !counter_input_pin && pin_q;
  assign act_edge  = edge_sel ? pin_fall : pin_rise;
  assign back_edge = edge_sel ? pin_rise : pin_fall;

  // ==========================================================
  // pulse measurement sequencer
  logic pw_end;

  // a level already active at enable is not an edge, so it never starts counting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pw_q <= TEC_PW_IDLE;
    end else begin
      unique case (pw_q)
        TEC_PW_IDLE: begin
          if (mode == TEC_MODE_PULSE && enable && act_edge) begin
            pw_q <= TEC_PW_MEAS;
          end
        end
        TEC_PW_MEAS: begin
          if (mode != TEC_MODE_PULSE || !enable || back_edge) begin
            pw_q <= TEC_PW_IDLE;
          end
        end
        default: pw_q <= TEC_PW_IDLE;
      endcase
    end
  end

  assign pw_end = (pw_q == TEC_PW_MEAS) && mode == TEC_MODE_PULSE && enable && back_edge;

  // ==========================================================
  // count tick selection
  logic tick;
  logic src_tick;

  always_comb begin
    unique case (mode)
      TEC_MODE_EVENT: src_tick = act_edge;
      TEC_MODE_TIMER: src_tick = tk.tick;
      TEC_MODE_PULSE: src_tick = tk.tick && (pw_q == TEC_PW_MEAS);
      default:        src_tick = 1'b0;
    endcase
  end

  // a counter read accepted in this cycle freezes the count; that tick is lost
  assign tick = enable && src_tick && !rd_cnt;

  // ==========================================================
  // counter and preload
  logic ovf;

  assign ovf = tick && (cnt_q == TEC_CNT_MAX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      preload_q <= TEC_CNT_RESET;
    end else if (wr_cnt) begin
      preload_q <= w_data_q[CW-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= TEC_CNT_RESET;
    end else if (wr_cnt && !enable) begin
      cnt_q <= w_data_q[CW-1:0];
    end else if (ovf) begin
      cnt_q <= preload_q;
    end else if (tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // control register; only pulse mode ever clears the enable itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= TEC_CTL_RESET;
    end else if (wr_ctl) begin
      ctl_q <= w_data_q[7:0] & ~(8'h01 << TEC_CTL_UNUSED);
    end else if (pw_end) begin
      ctl_q[TEC_CTL_EN] <= 1'b0;
    end
  end

  // ==========================================================
  // interrupt control: flag set by overflow wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_control_reg_q <= TEC_INTERRUPT_CONTROL_REG_RESET;
    end else begin
      if (wr_interrupt_control_reg) begin
        interrupt_control_reg_q <= w_data_q[7:0];
      end
      if (ovf) begin
        interrupt_control_reg_q[TEC_INTERRUPT_CONTROL_REG_FLAG] <= 1'b1;
      end
    end
  end

  assign overflow_irq = interrupt_control_reg_q[TEC_INTERRUPT_CONTROL_REG_FLAG] && interrupt_control_reg_q[TEC_INTERRUPT_CONTROL_REG_IE];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= ovf;
    end
  end

  assign overflow_wake = wake_q;

  // ==========================================================
  // frequency divider and buzzer pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pfd_q <= 1'b0;
    end else if (ovf) begin
      pfd_q <= !pfd_q;
    end
  end

  assign freq_divider_output = pfd_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pb_q <= TEC_PB_RESET;
    end else if (wr_pb) begin
      pb_q <= {3'h0, w_data_q[4:0]};
    end
  end

  logic bz_on;
  logic bz_gate;

  assign bz_on   = pb_q[TEC_PB_BZ];
  assign bz_gate = pb_q[TEC_PB_D0];

  // input-configured pins are never driven, buzzer or not
  assign port_b_bit0_oe = !pb_q[TEC_PB_IN0];
  assign port_b_bit1_oe = !pb_q[TEC_PB_IN1];
  assign port_b_bit0_o  = bz_on ? (bz_gate && pfd_q) : pb_q[TEC_PB_D0];
  assign port_b_bit1_o  = bz_on ? (bz_gate && !pfd_q) : pb_q[TEC_PB_D1];

endmodule // tec_top

// file: sim/tec_pin_model.sv
// partner: external source driving the counter input pin
module tec_pin_model (
  // clock
  input  wire logic aclk,
  // driven pin
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin = 1'b0;
  // ==========================================================
  // level held n cycles; long holds stand in for a slow source
  task automatic drive(input logic lvl, input int n);
    pin <= lvl;
    repeat (n) @(posedge aclk);
  endtask
endmodule // tec_pin_model

// file: sim/tec_top_assertions.sv
// checker: bus handshake and overflow output relations of tec_top
module tec_top_assertions (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // overflow outputs
  input wire logic        overflow_wake,
  input wire logic        freq_divider_output
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // handshake steps
  sequence aw_taken; s_axi_awvalid && s_axi_awready; endsequence
  sequence w_taken; s_axi_wvalid && s_axi_wready; endsequence
  sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
  wr_answer_a: assert property (aw_taken and w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  w_hold_a: assert property (w_taken |=> !s_axi_wready)
    else $error("write data accepted twice");
  rd_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read not answered");
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  wake_pulse_a: assert property (overflow_wake |=> !overflow_wake)
    else $error("wake longer than one cycle");
  pfd_wake_a: assert property ($changed(freq_divider_output) |-> ##[0:2] overflow_wake)
    else $error("divider moved without overflow");
endmodule // tec_top_assertions

bind tec_top tec_top_assertions chk_u (.*);

// file: sim/testbench.sv
// testbench: register-level tests of the timer/event counter
module testbench
  import tec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
  wire logic   counter_input_pin;
  logic        port_b_bit0_o, port_b_bit0_oe, port_b_bit1_o, port_b_bit1_oe;
  logic        overflow_irq, overflow_wake, freq_divider_output;
  logic [7:0]  v;
  int          err_total = 0, n_compared = 0, n;
  always #50 aclk = ~aclk;
  tec_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .counter_input_pin, .port_b_bit0_o, .port_b_bit0_oe, .port_b_bit1_o,
    .port_b_bit1_oe, .overflow_irq, .overflow_wake, .freq_divider_output);
  tec_pin_model pin_u (.aclk, .pin(counter_input_pin));
  // ==========================================================
  // bus tasks: signals move after an edge, readiness sampled at the edge
  // lag > 0 raises bready/rready only after that many edges, so the answer must stand
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int lag = 0);
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      last_resp = s_axi_bresp;
      if (lag == 1) s_axi_bready <= 1'b1;
      if (lag > 0) lag--;
    end while (s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input int lag = 0);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      v = s_axi_rdata[7:0];
      last_resp = s_axi_rresp;
      if (lag == 1) s_axi_rready <= 1'b1;
      if (lag > 0) lag--;
    end while (s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    check(v, e);
  endtask
  task automatic pulses(input int k);
    repeat (k) begin
      pin_u.drive(1'b1, 4);
      pin_u.drive(1'b0, 4);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(TEC_ADDR_PORTB, 8'h0f);
    wr(TEC_ADDR_CTRL, 8'h68);
    rd(TEC_ADDR_CTRL, 3);
    check(v, 8'h48);
    wr(TEC_ADDR_PRELOAD, 8'hf0, 3);
    check({6'h0, last_resp}, {6'h0, TEC_RESP_OKAY});
    rc(TEC_ADDR_PRELOAD, 8'hf0);
    wr(TEC_ADDR_CTRL, 8'h50);
    pin_u.drive(1'b1, 8);
    rc(TEC_ADDR_PRELOAD, 8'hf1);
    pin_u.drive(1'b0, 8);
    rc(TEC_ADDR_PRELOAD, 8'hf1);
    pulses(2);
    rc(TEC_ADDR_PRELOAD, 8'hf3);
    wr(TEC_ADDR_CTRL, 8'h58);
    pin_u.drive(1'b1, 8);
    rc(TEC_ADDR_PRELOAD, 8'hf3);
    pin_u.drive(1'b0, 8);
    rc(TEC_ADDR_PRELOAD, 8'hf4);
    wr(TEC_ADDR_PRELOAD, 8'hfe);
    rc(TEC_ADDR_PRELOAD, 8'hf4);
    pulses(12);
    rc(TEC_ADDR_PRELOAD, 8'hfe);
    rc(TEC_ADDR_INTERRUPT_CONTROL_REG, 8'h20);
    rc(TEC_ADDR_CTRL, 8'h58);
    check(8'(freq_divider_output), 8'h01);
    wr(TEC_ADDR_CTRL, 8'h48);
    pulses(2);
    rc(TEC_ADDR_PRELOAD, 8'hfe);
    // mode 00 with enable set must still never count
    wr(TEC_ADDR_CTRL, 8'h10);
    pulses(2);
    rc(TEC_ADDR_PRELOAD, 8'hfe);
    wr(TEC_ADDR_INTERRUPT_CONTROL_REG, 8'h24);
    check(8'(overflow_irq), 8'h01);
    wr(TEC_ADDR_INTERRUPT_CONTROL_REG, 8'h20);
    check(8'(overflow_irq), 8'h00);
    wr(TEC_ADDR_PORTB, 8'h11);
    check(8'({port_b_bit0_oe, port_b_bit0_o, port_b_bit1_oe, port_b_bit1_o}), 8'h0e);
    wr(TEC_ADDR_PORTB, 8'h10);
    check(8'({port_b_bit0_oe, port_b_bit0_o, port_b_bit1_oe, port_b_bit1_o}), 8'h0a);
    wr(TEC_ADDR_PORTB, 8'h19);
    check(8'({port_b_bit0_oe, port_b_bit1_oe}), 8'h02);
    rc(8'h00, 8'h00);
    check({6'h0, last_resp}, {6'h0, TEC_RESP_SLVERR});
    wr(8'h00, 8'h00);
    check({6'h0, last_resp}, {6'h0, TEC_RESP_SLVERR});
    // pulse width: 20 high cycles hold exactly 10 ticks of the /2 clock
    wr(TEC_ADDR_CTRL, 8'hc0);
    wr(TEC_ADDR_PRELOAD, 8'h00);
    wr(TEC_ADDR_CTRL, 8'hd0);
    pin_u.drive(1'b1, 20);
    pin_u.drive(1'b0, 10);
    rc(TEC_ADDR_PRELOAD, 8'h0a);
    rc(TEC_ADDR_CTRL, 8'hc0);
    pulses(2);
    rc(TEC_ADDR_PRELOAD, 8'h0a);
    pin_u.drive(1'b1, 4);
    wr(TEC_ADDR_CTRL, 8'hd0);
    pin_u.drive(1'b1, 20);
    pin_u.drive(1'b0, 10);
    rc(TEC_ADDR_PRELOAD, 8'h0a);
    rc(TEC_ADDR_CTRL, 8'hd0);
    // 10 ticks from fc wrap twice inside one measurement and end at fe
    wr(TEC_ADDR_INTERRUPT_CONTROL_REG, 8'h00);
    wr(TEC_ADDR_CTRL, 8'hc0);
    wr(TEC_ADDR_PRELOAD, 8'hfc);
    wr(TEC_ADDR_CTRL, 8'hd0);
    pin_u.drive(1'b1, 20);
    pin_u.drive(1'b0, 10);
    rc(TEC_ADDR_PRELOAD, 8'hfe);
    rc(TEC_ADDR_INTERRUPT_CONTROL_REG, 8'h20);
    // timer: preload ff overflows on every tick, so wake spacing is the divisor
    for (int c = 0; c < 8; c++) begin
      wr(TEC_ADDR_CTRL, 8'h80);
      wr(TEC_ADDR_PRELOAD, 8'hff);
      wr(TEC_ADDR_CTRL, 8'h90 | 8'(c));
      do @(posedge aclk); while (overflow_wake !== 1'b1);
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (overflow_wake !== 1'b1);
      check(8'(n - 1), 8'((2 << c) - 1));
    end
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    tally_and_finish();
  end
endmodule // testbench
